// ==== rtl/wfm_top.sv ====
`timescale 1ns/1ps
`include "wfm_consts.svh"
module wfm_top import wfm_pkg::*; (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire logic rx_frame_valid,
  input wire logic [28:0] rx_id,
  input wire logic [3:0] rx_dlc,
  input wire logic [63:0] rx_data,
  input wire logic [28:0] wake_id_pattern,
  input wire logic [7:0] id_mask_bits_28_21,
  input wire logic [23:0] expected_payload_bytes_2_0,
  output logic config_valid_flag,
  output logic wake_match
);

  // ---------------------------------------------------------------------------
  // Pin synchronisation
  // ---------------------------------------------------------------------------

  logic [2:0] pin_s;
  logic sck_s;
  logic cs_n_s;
  logic mosi_s;
  logic sck_prev_q;
  logic sck_prev_d;
  logic sck_rise;
  logic sck_fall;
  logic selected;

  // Chip select resets high so the port starts deselected
  wfm_sync #(
    .WIDTH(3),
    .RST_VAL(`WFM_SYNC_RST)
  ) u_sync (
    .core_clk(core_clk),
    .reset(reset),
    .async_in({spi_sck, spi_cs_n, spi_mosi}),
    .sync_out(pin_s)
  );

  // Edges are taken from the settled stage only
  always_comb begin
    sck_s = pin_s[2];
    cs_n_s = pin_s[1];
    mosi_s = pin_s[0];
    sck_prev_d = sck_s;
    sck_rise = sck_s & ~sck_prev_q;
    sck_fall = ~sck_s & sck_prev_q;
    selected = ~cs_n_s;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_prev_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Serial frame engine
  // ---------------------------------------------------------------------------

  wfm_spi_state_t st_q;
  wfm_spi_state_t st_d;
  logic [3:0] bit_cnt_q;
  logic [3:0] bit_cnt_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  wfm_addr_t addr_q;
  wfm_addr_t addr_d;
  logic we_q;
  logic we_d;
  wfm_byte_t out_q;
  wfm_byte_t out_d;
  logic miso_q;
  logic miso_d;
  logic oe_q;
  logic oe_d;
  logic rd_load_q;
  logic rd_load_d;
  logic wr_req_q;
  logic wr_req_d;
  wfm_byte_t wr_data_q;
  wfm_byte_t wr_data_d;
  wfm_byte_t rd_data;

  // Mode 0, MSB first: seven address bits, write bit, then one data byte.
  // SCK is oversampled, so its half period must span several core cycles.
  always_comb begin
    st_d = st_q;
    bit_cnt_d = bit_cnt_q;
    shift_d = shift_q;
    addr_d = addr_q;
    we_d = we_q;
    out_d = out_q;
    miso_d = miso_q;
    oe_d = selected;
    rd_load_d = 1'b0;
    wr_req_d = 1'b0;
    wr_data_d = wr_data_q;
    if (!selected) begin
      st_d = WFM_SPI_IDLE;
      bit_cnt_d = 4'h0;
      miso_d = 1'b0;
    end else begin
      unique case (st_q)
        WFM_SPI_IDLE: begin
          st_d = WFM_SPI_ADDR;
          bit_cnt_d = 4'h0;
          miso_d = 1'b0;
        end
        WFM_SPI_ADDR: begin
          if (sck_rise) begin
            shift_d = {shift_q[6:0], mosi_s};
            bit_cnt_d = bit_cnt_q + 4'h1;
            if (bit_cnt_q == `WFM_SPI_LAST_BIT) begin
              addr_d = shift_q[6:0];
              we_d = mosi_s;
              rd_load_d = 1'b1;
              bit_cnt_d = 4'h0;
              st_d = WFM_SPI_DATA;
            end
          end
        end
        WFM_SPI_DATA: begin
          // Read data is snapshotted once the address is known
          if (rd_load_q) begin
            out_d = rd_data;
          end
          if (sck_fall) begin
            miso_d = out_q[7];
            out_d = {out_q[6:0], 1'b0};
          end
          if (sck_rise) begin
            shift_d = {shift_q[6:0], mosi_s};
            bit_cnt_d = bit_cnt_q + 4'h1;
            if (bit_cnt_q == `WFM_SPI_LAST_BIT) begin
              wr_data_d = {shift_q[6:0], mosi_s};
              wr_req_d = we_q;
              st_d = WFM_SPI_DONE;
            end
          end
        end
        WFM_SPI_DONE: begin
          // Extra clocks before deselect are ignored
          st_d = WFM_SPI_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q <= WFM_SPI_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      addr_q <= 7'h00;
      we_q <= 1'b0;
      out_q <= 8'h00;
      miso_q <= 1'b0;
      oe_q <= 1'b0;
      rd_load_q <= 1'b0;
      wr_req_q <= 1'b0;
      wr_data_q <= 8'h00;
    end else begin
      st_q <= st_d;
      bit_cnt_q <= bit_cnt_d;
      shift_q <= shift_d;
      addr_q <= addr_d;
      we_q <= we_d;
      out_q <= out_d;
      miso_q <= miso_d;
      oe_q <= oe_d;
      rd_load_q <= rd_load_d;
      wr_req_q <= wr_req_d;
      wr_data_q <= wr_data_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------------

  wfm_byte_t mask_upper_mid_q;
  wfm_byte_t mask_upper_mid_d;
  wfm_byte_t mask_mid_q;
  wfm_byte_t mask_mid_d;
  logic [4:0] mask_low_q;
  logic [4:0] mask_low_d;
  logic [3:0] length_q;
  logic [3:0] length_d;
  wfm_byte_t payload7_q;
  wfm_byte_t payload7_d;
  wfm_byte_t payload6_q;
  wfm_byte_t payload6_d;
  wfm_byte_t payload5_q;
  wfm_byte_t payload5_d;
  wfm_byte_t payload4_q;
  wfm_byte_t payload4_d;
  wfm_byte_t payload3_q;
  wfm_byte_t payload3_d;
  logic cfg_valid_q;
  logic cfg_valid_d;
  logic match_pulse;

  // Register writes; reserved bits are simply never stored
  always_comb begin
    mask_upper_mid_d = mask_upper_mid_q;
    mask_mid_d = mask_mid_q;
    mask_low_d = mask_low_q;
    length_d = length_q;
    payload7_d = payload7_q;
    payload6_d = payload6_q;
    payload5_d = payload5_q;
    payload4_d = payload4_q;
    payload3_d = payload3_q;
    if (wr_req_q) begin
      case (addr_q)
        // RQ2: bits 20..13
        `WFM_OFF_MASK_UPPER_MID: mask_upper_mid_d = wr_data_q;
        // RQ3: bits 12..5
        `WFM_OFF_MASK_MID: mask_mid_d = wr_data_q;
        // RQ4: bits 4..0 at 6..2
        `WFM_OFF_MASK_LOW: mask_low_d = wr_data_q[`WFM_MASK_LOW_MSB:`WFM_MASK_LOW_LSB];
        // RQ6: low nibble only
        `WFM_OFF_LENGTH_CODE: length_d = wr_data_q[`WFM_LENGTH_MSB:0];
        // RQ9: one byte per register
        `WFM_OFF_PAYLOAD7: payload7_d = wr_data_q;
        `WFM_OFF_PAYLOAD6: payload6_d = wr_data_q;
        `WFM_OFF_PAYLOAD5: payload5_d = wr_data_q;
        `WFM_OFF_PAYLOAD4: payload4_d = wr_data_q;
        `WFM_OFF_PAYLOAD3: payload3_d = wr_data_q;
        default: begin
        end
      endcase
    end
  end

  // Valid flag: a write of one beats a same-cycle wake clear, so a fresh
  // confirmation is never lost; any mask, length or payload register write voids it.
  always_comb begin
    cfg_valid_d = cfg_valid_q;
    // RQ13: self clear on wake
    if (match_pulse) begin
      cfg_valid_d = 1'b0;
    end
    if (wr_req_q && wfm_is_cfg_addr(addr_q)) begin
      // RQ13: clear on changed setup
      cfg_valid_d = 1'b0;
    end else if (wr_req_q && addr_q == `WFM_OFF_CFG_VALID) begin
      // RQ14: controller confirms setup
      cfg_valid_d = wr_data_q[`WFM_CFG_VALID_BIT];
    end
  end

  // RQ10: reset clears all
  // RQ7: code zero is the cleared state
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mask_upper_mid_q <= `WFM_RST_BYTE;
      mask_mid_q <= `WFM_RST_BYTE;
      mask_low_q <= `WFM_RST_MASK_LOW;
      length_q <= `WFM_RST_LENGTH;
      payload7_q <= `WFM_RST_BYTE;
      payload6_q <= `WFM_RST_BYTE;
      payload5_q <= `WFM_RST_BYTE;
      payload4_q <= `WFM_RST_BYTE;
      payload3_q <= `WFM_RST_BYTE;
      cfg_valid_q <= `WFM_RST_CFG_VALID;
    end else begin
      mask_upper_mid_q <= mask_upper_mid_d;
      mask_mid_q <= mask_mid_d;
      mask_low_q <= mask_low_d;
      length_q <= length_d;
      payload7_q <= payload7_d;
      payload6_q <= payload6_d;
      payload5_q <= payload5_d;
      payload4_q <= payload4_d;
      payload3_q <= payload3_d;
      cfg_valid_q <= cfg_valid_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Read-back
  // ---------------------------------------------------------------------------

  // Unstored bits read zero in every case, including after a restart
  always_comb begin
    rd_data = 8'h00;
    case (addr_q)
      `WFM_OFF_MASK_UPPER_MID: rd_data = mask_upper_mid_q;
      `WFM_OFF_MASK_MID: rd_data = mask_mid_q;
      // RQ12: bits 7, 1, 0 read zero
      `WFM_OFF_MASK_LOW: rd_data = {1'b0, mask_low_q, 2'b00};
      // RQ11: upper nibble reads zero
      // RQ5: reserved bits read zero
      `WFM_OFF_LENGTH_CODE: rd_data = {4'h0, length_q};
      `WFM_OFF_PAYLOAD7: rd_data = payload7_q;
      `WFM_OFF_PAYLOAD6: rd_data = payload6_q;
      `WFM_OFF_PAYLOAD5: rd_data = payload5_q;
      `WFM_OFF_PAYLOAD4: rd_data = payload4_q;
      `WFM_OFF_PAYLOAD3: rd_data = payload3_q;
      `WFM_OFF_CFG_VALID: rd_data = {7'h00, cfg_valid_q};
      default: rd_data = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Frame matcher
  // ---------------------------------------------------------------------------

  logic [28:0] id_mask;
  logic [63:0] pattern_data;

  // Byte i of the payload sits at bits 8*i+7..8*i
  always_comb begin
    id_mask = {id_mask_bits_28_21, mask_upper_mid_q, mask_mid_q, mask_low_q};
    pattern_data = {payload7_q, payload6_q, payload5_q, payload4_q, payload3_q,
                    expected_payload_bytes_2_0};
  end

  wfm_matcher u_matcher (
    .core_clk(core_clk),
    .reset(reset),
    .enable(cfg_valid_q),
    .frame_valid(rx_frame_valid),
    .rx_id(rx_id),
    .rx_dlc(rx_dlc),
    .rx_data(rx_data),
    .pattern_id(wake_id_pattern),
    .id_mask(id_mask),
    .pattern_dlc(length_q),
    .pattern_data(pattern_data),
    .match_pulse(match_pulse)
  );

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------

  assign spi_miso = miso_q;
  assign spi_miso_oe = oe_q;
  assign config_valid_flag = cfg_valid_q;
  assign wake_match = match_pulse;

endmodule : wfm_top

// ==== rtl/wfm_consts.svh ====
`ifndef WFM_CONSTS_SVH
`define WFM_CONSTS_SVH
// Function
// RQ1: Mask bit zero ignores the identifier bit; one requires it to match.
// RQ2: Mask for identifier bits 20..13 sits in one byte, bit 20 on top.
// RQ3: Mask for identifier bits 12..5 sits in one byte, bit 12 at position 7.
// RQ4: Mask for identifier bits 4..0 sits at positions 6..2; others unused.
// RQ5: Reserved bits read zero and writes to them change nothing.
// RQ6: Length code is the low nibble; codes eight and above mean eight bytes.
// RQ7: Length code zero means an empty payload and also the cleared state.
// RQ8: Received length code must equal the configured code on every bit.
// RQ9: Each payload register holds one byte, bit 0 least significant.
// RQ10: Reset clears every mask, length-code and payload register to zero.
// RQ11: After a restart the upper nibble of the length register reads zero.
// RQ12: After a restart the unused low-mask bits 7, 1 and 0 read zero.
// RQ13: Valid flag clears on wake-up, reset, or any configuration change. A write of one to the flag in the same cycle as a wake-up keeps it set.
// RQ14: Controller checks configuration then sets valid; wake disabled until then.
// RQ15: Match needs unmasked identifier, length code and payload bytes to agree.

// ---------------------------------------------------------------------------
// Register offsets on the serial port
// ---------------------------------------------------------------------------
`define WFM_OFF_MASK_UPPER_MID 7'h28
`define WFM_OFF_MASK_MID 7'h29
`define WFM_OFF_MASK_LOW 7'h2a
`define WFM_OFF_LENGTH_CODE 7'h2b
`define WFM_OFF_PAYLOAD7 7'h2c
`define WFM_OFF_PAYLOAD6 7'h2d
`define WFM_OFF_PAYLOAD5 7'h2e
`define WFM_OFF_PAYLOAD4 7'h2f
`define WFM_OFF_PAYLOAD3 7'h30
`define WFM_OFF_CFG_VALID 7'h3f

// ---------------------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------------------
`define WFM_MASK_LOW_MSB 6
`define WFM_MASK_LOW_LSB 2
`define WFM_LENGTH_MSB 3
`define WFM_CFG_VALID_BIT 0
`define WFM_RST_BYTE 8'h00
`define WFM_RST_MASK_LOW 5'h00
`define WFM_RST_LENGTH 4'h0
`define WFM_RST_CFG_VALID 1'b0
`define WFM_MAX_BYTES 4'h8
`define WFM_SYNC_RST 3'h2

// ---------------------------------------------------------------------------
// Serial frame timing
// ---------------------------------------------------------------------------
`define WFM_SPI_LAST_BIT 4'h7
`endif

// ==== rtl/wfm_pkg.sv ====
`include "wfm_consts.svh"
package wfm_pkg;

  // Serial port frame phases
  typedef enum logic [1:0] {
    WFM_SPI_IDLE,
    WFM_SPI_ADDR,
    WFM_SPI_DATA,
    WFM_SPI_DONE
  } wfm_spi_state_t;

  typedef logic [6:0] wfm_addr_t;
  typedef logic [7:0] wfm_byte_t;

  // Payload length in bytes implied by a length code
  function automatic logic [3:0] wfm_dlc_len(input logic [3:0] dlc);
    return dlc[3] ? `WFM_MAX_BYTES : dlc;
  endfunction : wfm_dlc_len

  // True for any register whose change voids the configuration
  function automatic logic wfm_is_cfg_addr(input wfm_addr_t addr);
    return (addr >= `WFM_OFF_MASK_UPPER_MID) && (addr <= `WFM_OFF_PAYLOAD3);
  endfunction : wfm_is_cfg_addr

endpackage : wfm_pkg

// ==== rtl/wfm_sync.sv ====
`timescale 1ns/1ps
module wfm_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // Only the second stage reads the first; metastability settles there
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule : wfm_sync

// ==== rtl/wfm_matcher.sv ====
`timescale 1ns/1ps
`include "wfm_consts.svh"
module wfm_matcher import wfm_pkg::*; (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic frame_valid,
  input wire logic [28:0] rx_id,
  input wire logic [3:0] rx_dlc,
  input wire logic [63:0] rx_data,
  input wire logic [28:0] pattern_id,
  input wire logic [28:0] id_mask,
  input wire logic [3:0] pattern_dlc,
  input wire logic [63:0] pattern_data,
  output logic match_pulse
);

  logic match_q;
  logic match_d;
  logic id_ok;
  logic dlc_ok;
  logic data_ok;
  logic [3:0] len;

  // Compare the received frame against the stored pattern
  always_comb begin
    // RQ1: masked identifier compare
    id_ok = ((rx_id ^ pattern_id) & id_mask) == 29'h0;
    // RQ8: bitwise length code
    dlc_ok = rx_dlc == pattern_dlc;
    // RQ6: codes eight up mean eight
    len = wfm_dlc_len(pattern_dlc);
    data_ok = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < len && rx_data[8*i +: 8] != pattern_data[8*i +: 8]) begin
        data_ok = 1'b0;
      end
    end
    // RQ15: all fields must agree
    // RQ14: idle until configuration is valid
    match_d = enable & frame_valid & id_ok & dlc_ok & data_ok;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      match_q <= 1'b0;
    end else begin
      match_q <= match_d;
    end
  end

  assign match_pulse = match_q;

endmodule : wfm_matcher

// ==== testbench/wfm_can_node.sv ====
`timescale 1ns/1ps
// ----------
// Bus node model delivering received frames
// ----------
module wfm_can_node (
  input wire logic core_clk,
  output logic frame_valid,
  output logic [28:0] id,
  output logic [3:0] dlc,
  output logic [63:0] data
);
  // Quiet bus until the first frame
  initial begin
    frame_valid = 1'b0;
    id = '0;
    dlc = '0;
    data = '0;
  end

  // One-cycle strobe; fields are inverted afterwards so stale values never match
  task automatic send(input logic [28:0] f_id, input logic [3:0] f_dlc,
                      input logic [63:0] f_data);
    @(posedge core_clk);
    frame_valid <= 1'b1;
    id <= f_id;
    dlc <= f_dlc;
    data <= f_data;
    @(posedge core_clk);
    frame_valid <= 1'b0;
    id <= ~f_id;
    dlc <= ~f_dlc;
    data <= ~f_data;
  endtask : send
endmodule : wfm_can_node

// ==== testbench/wfm_checker.sv ====
`timescale 1ns/1ps
// ----------
// Port checker for the wake configuration block
// ----------
module wfm_checker (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_miso,
  input wire logic spi_miso_oe,
  input wire logic rx_frame_valid,
  input wire logic config_valid_flag,
  input wire logic wake_match
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // A frame taken and its match pulse one cycle later
  sequence s_match;
    rx_frame_valid ##1 wake_match;
  endsequence
  // Select pin high long enough to pass the synchroniser
  sequence s_desel;
    spi_cs_n [*5];
  endsequence
  sequence s_sel;
    !spi_cs_n [*5];
  endsequence

  match_cause_a: assert property (
    wake_match |-> $past(rx_frame_valid) && $past(config_valid_flag))
    else $error("match without a qualified frame");
  refuse_invalid_a: assert property (
    rx_frame_valid && !config_valid_flag |=> !wake_match)
    else $error("match while configuration not valid");
  match_clears_a: assert property (s_match |=> !config_valid_flag)
    else $error("valid flag kept after a wake match");
  reset_quiet_a: assert property (
    $fell(reset) |-> !config_valid_flag && !wake_match && !spi_miso_oe)
    else $error("outputs not cleared by reset");
  valid_rise_a: assert property ($rose(config_valid_flag) |-> $past(spi_miso_oe))
    else $error("valid flag set without a serial frame");
  valid_fall_a: assert property (
    $fell(config_valid_flag) |-> $past(wake_match) || $past(spi_miso_oe) || $past(reset))
    else $error("valid flag dropped without cause");
  oe_desel_a: assert property (s_desel |-> !spi_miso_oe)
    else $error("data out driven while deselected");
  oe_sel_a: assert property (s_sel |-> spi_miso_oe)
    else $error("data out not driven while selected");
  miso_fall_a: assert property (
    spi_miso_oe && $past(spi_miso_oe) && $changed(spi_miso) |->
      !$past(spi_sck) && !$past(spi_sck, 2))
    else $error("data out changed outside clock low phase");
endmodule : wfm_checker

bind wfm_top wfm_checker wfm_checker_i (
  .core_clk(core_clk),
  .reset(reset),
  .spi_sck(spi_sck),
  .spi_cs_n(spi_cs_n),
  .spi_miso(spi_miso),
  .spi_miso_oe(spi_miso_oe),
  .rx_frame_valid(rx_frame_valid),
  .config_valid_flag(config_valid_flag),
  .wake_match(wake_match)
);

// ==== testbench/wake_frame_match_config_test.sv ====
`timescale 1ns/1ps
`include "wfm_consts.svh"
// ----------
// Bench for the wake configuration block
// ----------
module wake_frame_match_config_test import wfm_pkg::*;;
  typedef struct {wfm_addr_t a; wfm_byte_t w; wfm_byte_t r;} wfm_row_t;
  logic core_clk, reset, spi_sck, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  logic rx_frame_valid, config_valid_flag, wake_match;
  logic [28:0] rx_id, pat;
  logic [3:0] rx_dlc;
  logic [63:0] rx_data, dat;
  logic [7:0] mask_hi;
  logic [23:0] low_bytes;
  wfm_byte_t rd;
  int n_fail, compares;
  // Write value beside expected read-back; last row is unmapped
  wfm_row_t rows[10] = '{'{7'h28, 8'hff, 8'hff}, '{7'h29, 8'ha5, 8'ha5},
    '{7'h2a, 8'hff, 8'h7c}, '{7'h2b, 8'hff, 8'h0f}, '{7'h2c, 8'h80, 8'h80},
    '{7'h2d, 8'h01, 8'h01}, '{7'h2e, 8'h5a, 8'h5a}, '{7'h2f, 8'hc3, 8'hc3},
    '{7'h30, 8'h3c, 8'h3c}, '{7'h15, 8'hff, 8'h00}};

  wfm_top wfm_top_i (.core_clk(core_clk), .reset(reset), .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .rx_frame_valid(rx_frame_valid), .rx_id(rx_id),
    .rx_dlc(rx_dlc), .rx_data(rx_data), .wake_id_pattern(pat),
    .id_mask_bits_28_21(mask_hi), .expected_payload_bytes_2_0(low_bytes),
    .config_valid_flag(config_valid_flag), .wake_match(wake_match));
  wfm_can_node wfm_can_node_i (.core_clk(core_clk), .frame_valid(rx_frame_valid),
    .id(rx_id), .dlc(rx_dlc), .data(rx_data));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic ticks(input int n);
    repeat (n) @(posedge core_clk);
  endtask : ticks

  // Mode 0 frame, six core cycles per clock phase to clear the synchroniser
  task automatic xfer(input wfm_addr_t a, input logic w, input wfm_byte_t d);
    logic [15:0] word;
    word = {a, w, d};
    @(posedge core_clk);
    spi_cs_n <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      spi_sck <= 1'b0;
      spi_mosi <= word[15 - i];
      ticks(6);
      if (i >= 8) rd[15 - i] = spi_miso;
      spi_sck <= 1'b1;
      ticks(6);
    end
    spi_sck <= 1'b0;
    ticks(6);
    spi_cs_n <= 1'b1;
    ticks(5);
  endtask : xfer

  task automatic set_valid();
    xfer(`WFM_OFF_CFG_VALID, 1'b1, 8'h01);
  endtask : set_valid

  // Send a frame, then look for a match pulse over a short bounded window
  task automatic try_frame(input logic [28:0] id, input logic [3:0] dlc,
                           input logic [63:0] data, input logic exp);
    logic hit;
    hit = 1'b0;
    wfm_can_node_i.send(id, dlc, data);
    repeat (3) begin
      #1 hit = hit | wake_match;
      @(posedge core_clk);
    end
    check("wake_match", {7'h00, hit}, {7'h00, exp});
  endtask : try_frame

  // Hang guard: running out counts as a mismatch
  initial begin
    ticks(50000);
    n_fail++;
    end_of_test();
  end

  initial begin
    reset = 1'b1;
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
    n_fail = 0;
    compares = 0;
    pat = 29'h1234567;
    mask_hi = 8'hff;
    low_bytes = 24'h332211;
    dat = 64'h80015ac33c332211;
    ticks(4);
    reset <= 1'b0;
    ticks(4);
    for (int i = 0; i < 9; i++) begin
      xfer(rows[i].a, 1'b0, 8'h00);
      check("reset value", rd, 8'h00);
    end
    for (int i = 0; i < 10; i++) begin
      xfer(rows[i].a, 1'b1, rows[i].w);
      xfer(rows[i].a, 1'b0, 8'h00);
      check("read back", rd, rows[i].r);
    end
    // Matching needs the flag; each match voids it
    try_frame(pat, 4'hf, dat, 1'b0);
    set_valid();
    // The flag register reads back what the controller confirmed
    xfer(`WFM_OFF_CFG_VALID, 1'b0, 8'h00);
    check("valid read", rd, 8'h01);
    try_frame(pat, 4'hf, dat, 1'b1);
    check("valid flag", {7'h00, config_valid_flag}, 8'h00);
    set_valid();
    try_frame(pat, 4'h8, dat, 1'b0);
    try_frame(pat ^ 29'h1, 4'hf, dat, 1'b0);
    try_frame(pat ^ 29'h2000, 4'hf, dat, 1'b0);
    try_frame(pat ^ 29'h20, 4'hf, dat, 1'b0);
    try_frame(pat, 4'hf, dat ^ 64'h0000010000000000, 1'b0);
    // Clearing mask for id bit 0 voids the flag and stops comparing it
    xfer(7'h2a, 1'b1, 8'h78);
    check("valid flag", {7'h00, config_valid_flag}, 8'h00);
    set_valid();
    try_frame(pat ^ 29'h1, 4'hf, dat, 1'b1);
    // Short length: bytes beyond the code are not compared
    xfer(7'h2b, 1'b1, 8'h02);
    set_valid();
    try_frame(pat, 4'h2, 64'h2211, 1'b1);
    // Controller may withdraw its confirmation by writing zero
    set_valid();
    xfer(`WFM_OFF_CFG_VALID, 1'b1, 8'h00);
    check("valid flag", {7'h00, config_valid_flag}, 8'h00);
    // Second reset mid-run clears configuration again
    set_valid();
    reset <= 1'b1;
    ticks(2);
    reset <= 1'b0;
    ticks(4);
    xfer(7'h29, 1'b0, 8'h00);
    check("reset value", rd, 8'h00);
    check("valid flag", {7'h00, config_valid_flag}, 8'h00);
    end_of_test();
  end
endmodule : wake_frame_match_config_test
